// *** common/drr_defines.vh ***
/*
 * Holds the shared constants of the display readout and remote override block:
 * phase codes, address widths, calibrator bit, timing counts and bus offsets.
 * Assumes inclusion by its bare name from design and bench files.
 */
// Function
// - latch at latch phase end, sample at next sample phase
// - single trace pulses every location each sweep
// - dual trace halves pulses, doubles integration time
// - halved rate from modified versus plain lsb
// - even samples shown left of odd samples
// - address bit nine drives calibrator square wave
// - takeover releases lines, inhibit high, bias low
// - takeover disables freeze and alternate freeze buttons
// - inhibit high ignores front panel arm button
// - bias low lets single external arm set latch
// - external clock select releases range lines high
// - plain signals active high, inverted active low
// - ten megahertz clock, five phases of two megahertz
// - twelve bit read counter stepped each strobe
// - global clear on power-on, release, normal mode
// - plot access suspends write chain, not readout
// - plot abort ends plot, clears plot counter
// - no alternate hold, both latches equal, lsb selects
`ifndef DRR_DEFINES_VH
`define DRR_DEFINES_VH

// ***************************************************************
// timing
// ***************************************************************
`define DRR_CLK_HZ 10000000
`define DRR_PHASE_COUNT 5
`define DRR_PHASE_HZ 2000000
`define DRR_CLEAR_CYCLES 4

// ***************************************************************
// phase one-hot codes (bit 0 is the first phase)
// ***************************************************************
`define DRR_PH1 5'h01
`define DRR_PH2 5'h02
`define DRR_PH3 5'h04
`define DRR_PH4 5'h08
`define DRR_PH5 5'h10

// ***************************************************************
// read address
// ***************************************************************
`define DRR_ADDR_W 12
`define DRR_CAL_BIT 9
`define DRR_RANGE_W 3

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define DRR_REG_CTRL 4'h0
`define DRR_REG_STATUS 4'h4
`define DRR_REG_ADDR 4'h8
`define DRR_REG_PLOT 4'hC

// control register fields
`define DRR_CTRL_DUAL 0
`define DRR_CTRL_STORAGE 1
`define DRR_CTRL_ALT_HOLD 2
`define DRR_CTRL_PLOT_REQ 3
`define DRR_CTRL_PLOT_ABORT 4
`define DRR_CTRL_RELEASE 5
`define DRR_CTRL_RESET 32'h00000000

`endif

// *** logic/drr_phase_gen.v ***
/*
 * Five-phase sequencer on the master clock.
 * Assumes a free-running clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "drr_defines.vh"

module drr_phase_gen (
  input wire ref_clk, // master clock
  input wire reset, // async reset, high
  output reg [4:0] clock_phases // one-hot phase
);

  // ***************************************************************
  // ring
  // ***************************************************************
  // ring rotates one place per edge; exactly one bit set
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clock_phases <= `DRR_PH1;
    end else begin
      case (clock_phases)
        `DRR_PH1: clock_phases <= `DRR_PH2;
        `DRR_PH2: clock_phases <= `DRR_PH3;
        `DRR_PH3: clock_phases <= `DRR_PH4;
        `DRR_PH4: clock_phases <= `DRR_PH5;
        `DRR_PH5: clock_phases <= `DRR_PH1;
        default: clock_phases <= `DRR_PH1; // recovers from a corrupt ring
      endcase
    end
  end

endmodule // drr_phase_gen
`default_nettype wire

// *** logic/drr_readout.v ***
/*
 * Display readout sequencing and remote takeover for the storage display.
 * Holds the read counter, converter latch and sample pulse timing, the
 * calibrator drive, remote line control, arm latch gating and a small
 * Avalon-MM slave. Assumes all inputs synchronous to ref_clk; open-collector
 * lines are resolved by the surroundings from the output enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "drr_defines.vh"

module drr_readout #(
  parameter ADDR_W = `DRR_ADDR_W, // read counter width
  parameter DATA_W = 8 // store data width
) (
  input wire ref_clk, // master clock, 10 MHz
  input wire reset, // async reset, high
  // avalon-mm slave
  input wire [3:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes
  output reg [31:0] avs_readdata, // read data
  output reg avs_waitrequest, // stall
  // sample store side
  input wire [DATA_W-1:0] store_data, // store output
  output reg [ADDR_W-1:0] read_address_bits, // read address
  output reg [DATA_W-1:0] converter_data, // latched to converter
  output reg sample_pulse, // sample switch drive
  output reg integ_double, // doubled integration time
  output reg read_strobe, // 2 MHz read strobe
  output reg calibrator_drive, // calibrator switch
  output reg global_clear, // global clear
  output reg plotter_store_access_n, // store access to plotter, low
  output reg write_chain_enable, // write chain running
  output reg [ADDR_W-1:0] plot_address, // plot address counter
  // remote socket and front panel
  input wire remote_takeover_n, // remote takeover, low
  input wire [3:0] released_in, // resolved released lines
  output reg [3:0] released_out, // released lines drive value
  output reg [3:0] released_oe, // released lines enable
  output reg arm_inhibit_line, // arm inhibit
  output reg arm_bias_line, // arm bias
  input wire power_on, // power-on strobe
  input wire panel_freeze, // front panel display freeze
  input wire panel_alt_freeze, // front panel alternate freeze
  input wire panel_arm, // front panel arm button
  input wire external_arm, // external arm signal
  output reg display_freeze, // effective display freeze
  output reg alternate_sample_freeze, // effective alternate freeze
  output reg arm_latch, // arm set-reset latch state
  input wire arm_clear, // clears the arm latch
  input wire ext_clock_select_n, // external clock select, low
  input wire [`DRR_RANGE_W-1:0] range_in, // resolved range lines
  output reg [`DRR_RANGE_W-1:0] range_out, // range drive value
  output reg [`DRR_RANGE_W-1:0] range_oe, // range drive enable
  output reg ext_clock_chosen // external clock selected
);

  localparam [ADDR_W-1:0] ADDR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};
  localparam [`DRR_RANGE_W-1:0] RANGE_EXT = {`DRR_RANGE_W{1'b1}};
  localparam [31:0] CLEAR_LOAD = `DRR_CLEAR_CYCLES; // cut to the stretch counter on load

  wire [4:0] clock_phases;
  wire latch_phase = clock_phases[4];
  wire sample_phase = clock_phases[3];

  reg [31:0] ctrl;
  reg storage_d;
  reg release_d;
  reg [2:0] clear_cnt;
  reg read_lsb_mod;
  reg sample_due;
  reg [DATA_W-1:0] ch_even;
  reg [DATA_W-1:0] ch_odd;
  reg plot_active;
  reg [31:0] next_readdata;

  wire dual = ctrl[`DRR_CTRL_DUAL];
  wire alt_hold = ctrl[`DRR_CTRL_ALT_HOLD];
  wire remote = ~remote_takeover_n;
  wire storage = ctrl[`DRR_CTRL_STORAGE];
  wire release_bit = ctrl[`DRR_CTRL_RELEASE];

  // ***************************************************************
  // phases
  // ***************************************************************
  drr_phase_gen drr_phase_gen_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .clock_phases(clock_phases)
  );

  // ***************************************************************
  // global clear
  // ***************************************************************
  // clear stretched a few cycles on power-on, release or leaving storage
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      storage_d <= 1'b0;
      release_d <= 1'b0;
      clear_cnt <= 3'h0;
      global_clear <= 1'b1;
    end else begin
      storage_d <= storage;
      release_d <= release_bit;
      if (power_on || (release_bit && !release_d) || (storage_d && !storage)) begin
        clear_cnt <= CLEAR_LOAD[2:0];
      end else if (clear_cnt != 3'h0) begin
        clear_cnt <= clear_cnt - 3'h1;
      end
      global_clear <= power_on || (release_bit && !release_d) ||
                      (storage_d && !storage) || (clear_cnt != 3'h0);
    end
  end

  // ***************************************************************
  // read counter and converter latch
  // ***************************************************************
  // address steps with the strobe at the end of the latch phase, so the
  // sample switch pulse of the next cycle sees settled converter data
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      read_address_bits <= {ADDR_W{1'b0}};
      read_strobe <= 1'b0;
      converter_data <= {DATA_W{1'b0}};
      ch_even <= {DATA_W{1'b0}};
      ch_odd <= {DATA_W{1'b0}};
      read_lsb_mod <= 1'b0;
      sample_due <= 1'b0;
      sample_pulse <= 1'b0;
      integ_double <= 1'b0;
      calibrator_drive <= 1'b0;
    end else begin
      read_strobe <= latch_phase;
      integ_double <= dual;
      calibrator_drive <= read_address_bits[`DRR_CAL_BIT];
      if (global_clear) begin
        read_address_bits <= {ADDR_W{1'b0}};
        read_lsb_mod <= 1'b0;
        sample_due <= 1'b0;
        sample_pulse <= 1'b0;
      end else begin
        if (latch_phase) begin
          read_address_bits <= read_address_bits + ADDR_ONE;
          // modified lsb flips each full sweep so dual trace shows one channel
          if (&read_address_bits) begin
            read_lsb_mod <= ~read_lsb_mod;
          end
          // channel latches: equal unless alternate hold is set
          if (!alt_hold || !read_address_bits[0]) begin
            ch_even <= store_data;
          end
          if (!alt_hold || read_address_bits[0]) begin
            ch_odd <= store_data;
          end
          // route selected by modified lsb; even data always in even slot
          converter_data <= (read_lsb_mod ? (alt_hold ? ch_odd : store_data)
                                          : (alt_hold ? ch_even : store_data));
          // single trace: every location; dual: only matching parity
          sample_due <= !dual || (read_address_bits[0] == read_lsb_mod);
        end
        sample_pulse <= sample_due && clock_phases[2];
        if (sample_phase) begin
          sample_due <= 1'b0;
        end
      end
    end
  end

  // ***************************************************************
  // remote takeover and front panel
  // ***************************************************************
  // released lines never pulled low nor driven high; enables held off in every mode (wired-and)
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      released_out <= 4'h0;
      released_oe <= 4'h0;
      arm_inhibit_line <= 1'b0;
      arm_bias_line <= 1'b1;
      display_freeze <= 1'b0;
      alternate_sample_freeze <= 1'b0;
      arm_latch <= 1'b0;
    end else begin
      released_out <= 4'h0;
      released_oe <= 4'h0;
      arm_inhibit_line <= remote;
      arm_bias_line <= ~remote;
      display_freeze <= panel_freeze && !remote;
      alternate_sample_freeze <= panel_alt_freeze && !remote;
      if (global_clear) begin
        arm_latch <= 1'b0;
      end else if ((panel_arm && !arm_inhibit_line) ||
                   (external_arm && !arm_bias_line)) begin
        arm_latch <= 1'b1;
      end else if (arm_clear) begin
        arm_latch <= 1'b0; // an arm landing with the clear is kept
      end
    end
  end

  // ***************************************************************
  // clock range lines
  // ***************************************************************
  // released high when external clock select is low; all high selects it
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      range_out <= {`DRR_RANGE_W{1'b0}};
      range_oe <= {`DRR_RANGE_W{1'b0}};
      ext_clock_chosen <= 1'b0;
    end else begin
      range_out <= {`DRR_RANGE_W{1'b0}};
      range_oe <= {`DRR_RANGE_W{1'b0}};
      ext_clock_chosen <= !ext_clock_select_n && (range_in == RANGE_EXT);
    end
  end

  // ***************************************************************
  // plot access
  // ***************************************************************
  // plot takes store access by stopping writes; readout keeps running
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      plot_active <= 1'b0;
      plot_address <= {ADDR_W{1'b0}};
      plotter_store_access_n <= 1'b1;
      write_chain_enable <= 1'b0;
    end else begin
      if (ctrl[`DRR_CTRL_PLOT_ABORT] || global_clear) begin
        plot_active <= 1'b0;
        plot_address <= {ADDR_W{1'b0}};
      end else if (ctrl[`DRR_CTRL_PLOT_REQ] && !plot_active) begin
        plot_active <= 1'b1;
      end else if (plot_active && latch_phase) begin
        plot_address <= plot_address + ADDR_ONE;
        if (&plot_address) begin
          plot_active <= 1'b0;
        end
      end
      plotter_store_access_n <= ~plot_active;
      write_chain_enable <= storage && !plot_active;
    end
  end

  // ***************************************************************
  // avalon-mm slave
  // ***************************************************************
  // read data mux; unmapped offsets read zero
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `DRR_REG_CTRL: next_readdata = ctrl;
      `DRR_REG_STATUS: next_readdata = {20'h00000, released_in, ext_clock_chosen, arm_latch,
                                        remote, plot_active, global_clear,
                                        read_lsb_mod, display_freeze,
                                        alternate_sample_freeze};
      `DRR_REG_ADDR: next_readdata = {20'h00000, read_address_bits};
      `DRR_REG_PLOT: next_readdata = {20'h00000, plot_address};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // one wait cycle per access; plot commands self-clear after one cycle
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `DRR_CTRL_RESET;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      ctrl[`DRR_CTRL_PLOT_REQ] <= 1'b0;
      ctrl[`DRR_CTRL_PLOT_ABORT] <= 1'b0;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      // write lands only at the edge where the master sees waitrequest low
      if (avs_write && !avs_waitrequest && (avs_address == `DRR_REG_CTRL) &&
          avs_byteenable[0]) begin
        ctrl[5:0] <= avs_writedata[5:0];
      end
    end
  end

endmodule // drr_readout
`default_nettype wire

// *** sim/drr_remote_model.sv ***
/* remote controller model on the instrument socket.
   assumes pulled-up open-collector lines resolved here */
`timescale 1ns/1ps
`default_nettype none
module drr_remote_model (
  input wire logic [3:0] released_out, // device drive
  input wire logic [3:0] released_oe, // device enable
  input wire logic [2:0] range_out, // device drive
  input wire logic [2:0] range_oe, // device enable
  input wire logic ctl_en, // controller drives
  input wire logic [3:0] ctl_val, // controller value
  output logic [3:0] released_in, // resolved lines
  output logic [2:0] range_in // resolved range
);
  // wired-and with pull-up, so any low driver wins
  assign released_in = (~released_oe | released_out) & (ctl_en ? ctl_val : 4'hF);
  // range lines left undriven: pull-up picks the outside clock
  assign range_in = ~range_oe | range_out;
endmodule // drr_remote_model
`default_nettype wire

// *** sim/drr_readout_chk.sv ***
/* port assertions for the readout block.
   assumes a bind from the bench top, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module drr_readout_chk #(parameter ADDR_W = 12) (
  input wire logic ref_clk, // clock
  input wire logic reset, // reset
  input wire logic read_strobe, // strobe
  input wire logic [ADDR_W-1:0] read_address_bits, // address
  input wire logic [7:0] store_data, // store out
  input wire logic [7:0] converter_data, // latched
  input wire logic sample_pulse, // sample
  input wire logic integ_double, // dual
  input wire logic calibrator_drive, // cal
  input wire logic global_clear, // clear
  input wire logic write_chain_enable, // writing
  input wire logic plotter_store_access_n, // plot
  input wire logic remote_takeover_n, // remote
  input wire logic [3:0] released_oe, // enables
  input wire logic arm_inhibit_line, // inhibit
  input wire logic arm_bias_line, // bias
  input wire logic display_freeze, // freeze
  input wire logic alternate_sample_freeze, // alt freeze
  input wire logic ext_clock_select_n, // ext sel
  input wire logic [2:0] range_oe, // range en
  input wire logic ext_clock_chosen // ext clock
);
  // ****
  // readout timing
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // one strobe every five master cycles
  sequence s_gap;
    !read_strobe [*4] ##1 read_strobe;
  endsequence
  a_strobe_cadence: assert property (read_strobe |=> s_gap)
    else $error("strobe spacing wrong");
  a_addr_step: assert property (read_strobe && !global_clear && !$past(global_clear) |->
    read_address_bits == ADDR_W'($past(read_address_bits) + 1'b1)) else $error("address step");
  a_conv_latch: assert property (read_strobe && !$past(global_clear) |->
    converter_data == $past(store_data))
    else $error("converter data");
  a_single_pulse: assert property (read_strobe && !integ_double && write_chain_enable
    |-> ##[0:4] sample_pulse) else $error("missing sample");
  a_dual_halve: assert property (sample_pulse && integ_double |=> !sample_pulse [*8])
    else $error("dual rate");
  a_cal_follow: assert property (calibrator_drive == $past(read_address_bits[9]))
    else $error("calibrator");
  a_plot_chain: assert property (!plotter_store_access_n |-> !write_chain_enable)
    else $error("write chain");
  // ****
  // remote lines
  // ****
  a_remote_lines: assert property (!remote_takeover_n && !$past(remote_takeover_n) |->
    released_oe == 4'h0 && arm_inhibit_line && !arm_bias_line && !display_freeze
    && !alternate_sample_freeze) else $error("remote lines");
  a_local_lines: assert property (remote_takeover_n && $past(remote_takeover_n) |->
    !arm_inhibit_line && arm_bias_line) else $error("local lines");
  a_ext_clock: assert property (!ext_clock_select_n && !$past(ext_clock_select_n) |->
    range_oe == 3'h0 && ext_clock_chosen) else $error("ext clock");
endmodule // drr_readout_chk
`default_nettype wire

// *** sim/drr_readout_tb.sv ***
/* self-checking bench for the readout block.
   assumes the remote model and the checker bound below */
`timescale 1ns/1ps
`default_nettype none
`include "drr_defines.vh"
module drr_readout_tb;
  logic ref_clk = 0, reset = 1, avs_read = 0, avs_write = 0, ctl_en = 0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, ctl_val = 4'hF;
  logic [31:0] avs_writedata = 32'h0, rd;
  logic remote_takeover_n = 1, power_on = 0, panel_freeze = 0, panel_alt_freeze = 0;
  logic panel_arm = 0, external_arm = 0, arm_clear = 0, ext_clock_select_n = 1;
  wire [31:0] avs_readdata;
  wire [11:0] read_address_bits, plot_address;
  wire [7:0] converter_data;
  wire [3:0] released_in, released_out, released_oe;
  wire [2:0] range_in, range_out, range_oe;
  wire avs_waitrequest, sample_pulse, integ_double, read_strobe, calibrator_drive;
  wire global_clear, plotter_store_access_n, write_chain_enable, arm_inhibit_line;
  wire arm_bias_line, display_freeze, alternate_sample_freeze, arm_latch, ext_clock_chosen;
  // store model: contents follow the address
  wire [7:0] store_data = read_address_bits[7:0] ^ 8'hA5;
  int miscompares = 0, n_checks = 0, n, k;
  localparam logic [31:0] ST = 32'h1 << `DRR_CTRL_STORAGE;
  localparam logic [31:0] DU = 32'h1 << `DRR_CTRL_DUAL;
  drr_readout drr_readout_inst (.*);
  drr_remote_model drr_remote_model_inst (.*);
  always #50 ref_clk = ~ref_clk;
  // ****
  // shared tasks
  // ****
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    miscompares++;
    $display("ERROR %0t timeout", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) tmo();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic pulses(input int c);
    k = 0;
    repeat (c) begin
      @(posedge ref_clk);
      if (sample_pulse === 1'b1) k++;
    end
  endtask
  task automatic clr_len;
    for (n = 0; n < 10 && global_clear !== 1'b1; n++) @(posedge ref_clk);
    for (k = 0; k < 20 && global_clear === 1'b1; k++) @(posedge ref_clk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    bus(0, `DRR_REG_CTRL, 0);
    chk(rd, `DRR_CTRL_RESET, "ctrl reset");
    bus(0, 4'h2, 0);
    chk(rd, 32'h0, "unmapped read");
    avs_byteenable <= 4'hE;
    bus(1, `DRR_REG_CTRL, ST);
    avs_byteenable <= 4'hF;
    bus(0, `DRR_REG_CTRL, 0);
    chk(rd, 32'h0, "lane ignored");
    $display("t_regs done");
  endtask
  task automatic t_single;
    logic [11:0] a0;
    bus(1, `DRR_REG_CTRL, ST);
    cyc(20);
    a0 = read_address_bits;
    pulses(50);
    chk(k, 10, "single pulses");
    chk(12'(read_address_bits - a0), 12'hA, "address steps");
    for (n = 0; n < 10 && read_strobe !== 1'b1; n++) @(posedge ref_clk);
    chk(converter_data, 8'(read_address_bits - 1'b1) ^ 8'hA5, "latched data");
    $display("t_single done");
  endtask
  task automatic t_dual;
    logic c;
    bus(1, `DRR_REG_CTRL, ST | DU);
    cyc(20);
    chk(integ_double, 1'b1, "integ double");
    pulses(100);
    chk(k, 10, "dual pulses");
    c = calibrator_drive;
    for (n = 0; n < 3000 && calibrator_drive === c; n++) @(posedge ref_clk);
    if (n == 3000) tmo();
    chk(calibrator_drive, read_address_bits[9], "calibrator");
    $display("t_dual done");
  endtask
  task automatic t_plot;
    logic [11:0] a0;
    bus(1, `DRR_REG_CTRL, ST | (32'h1 << `DRR_CTRL_PLOT_REQ));
    cyc(10);
    chk(plotter_store_access_n, 1'b0, "plot access");
    chk(write_chain_enable, 1'b0, "write chain");
    a0 = read_address_bits;
    cyc(20);
    chk(12'(read_address_bits - a0), 12'h4, "readout moves");
    bus(1, `DRR_REG_CTRL, ST | (32'h1 << `DRR_CTRL_PLOT_ABORT));
    cyc(3);
    chk(plotter_store_access_n, 1'b1, "abort ends");
    chk(plot_address, 12'h0, "abort clears");
    $display("t_plot done");
  endtask
  task automatic t_clear;
    bus(1, `DRR_REG_CTRL, 0);
    clr_len();
    chk(k, 5, "normal mode clear");
    power_on <= 1'b1;
    cyc(1);
    power_on <= 1'b0;
    clr_len();
    chk(k, 5, "power-on clear");
    bus(1, `DRR_REG_CTRL, 32'h1 << `DRR_CTRL_RELEASE);
    clr_len();
    chk(k, 5, "release clear");
    $display("t_clear done");
  endtask
  task automatic t_remote;
    remote_takeover_n <= 1'b0;
    panel_freeze <= 1'b1;
    panel_alt_freeze <= 1'b1;
    ctl_en <= 1'b1;
    ctl_val <= 4'h5;
    cyc(1);
    // arm button only once the inhibit line has had its edge to rise
    panel_arm <= 1'b1;
    cyc(3);
    chk({arm_inhibit_line, arm_bias_line, released_oe, released_out}, 10'h200, "remote lines");
    chk({display_freeze, alternate_sample_freeze}, 2'h0, "freeze off");
    chk(arm_latch, 1'b0, "panel arm ignored");
    chk(released_in, 4'h5, "wired-and");
    bus(0, `DRR_REG_STATUS, 0);
    chk(rd[11:5], 7'h29, "status remote");
    external_arm <= 1'b1;
    cyc(1);
    external_arm <= 1'b0;
    cyc(2);
    chk(arm_latch, 1'b1, "external arm");
    panel_arm <= 1'b0;
    arm_clear <= 1'b1;
    cyc(1);
    arm_clear <= 1'b0;
    remote_takeover_n <= 1'b1;
    ctl_en <= 1'b0;
    cyc(3);
    chk({arm_latch, display_freeze}, 2'h1, "local again");
    $display("t_remote done");
  endtask
  task automatic t_ext;
    ext_clock_select_n <= 1'b0;
    cyc(3);
    chk({ext_clock_chosen, range_oe, range_out}, 7'h40, "ext clock");
    bus(0, `DRR_REG_STATUS, 0);
    chk(rd[7], 1'b1, "status ext");
    $display("t_ext done");
  endtask
  initial begin
    cyc(4);
    reset <= 1'b0;
    t_regs();
    t_single();
    t_dual();
    t_plot();
    t_clear();
    t_remote();
    t_ext();
    end_sim();
  end
endmodule // drr_readout_tb
bind drr_readout drr_readout_chk #(.ADDR_W(ADDR_W)) drr_readout_chk_inst (.*);
`default_nettype wire
